// *** src/vout_limit_pkg.sv ***
// Command codes, field layouts and reset values for the output target register group
`default_nettype none
package vout_limit_pkg;

   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CODE_TRIM    = 8'h23;
   localparam logic [7:0] CODE_CEILING = 8'h24;
   localparam logic [7:0] CODE_MHIGH   = 8'h25;
   localparam logic [7:0] CODE_MLOW    = 8'h26;
   localparam logic [7:0] CODE_MAKER   = 8'h27;
   localparam logic [7:0] CODE_PART    = 8'h28;
   localparam int         NUM_REGS     = 6;
   localparam int         IDX_W        = 3;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int          DATA_W      = 16;
   localparam int          VID_W       = 9;
   localparam int          TRIM_W      = 8;
   localparam int          TRIM_SIGN   = 7;
   localparam logic [15:0] MASK_VID    = 16'h01FF;
   localparam logic [15:0] MASK_BYTE   = 16'h00FF;

   // Field mask per register, in code order
   localparam logic [15:0] REG_MASK [NUM_REGS] = '{
      MASK_BYTE, MASK_VID, MASK_VID, MASK_VID, MASK_BYTE, MASK_BYTE};

   // Reset values (plain defaults; identity bytes are arbitrary)
   localparam logic [15:0] RST_TRIM    = 16'h0000;
   localparam logic [15:0] RST_CEILING = 16'h01FF;
   localparam logic [15:0] RST_MHIGH   = 16'h0000;
   localparam logic [15:0] RST_MLOW    = 16'h0000;
   localparam logic [15:0] RST_MAKER   = 16'h005A;
   localparam logic [15:0] RST_PART    = 16'h00A5;
   localparam logic [15:0] REG_RESET [NUM_REGS] = '{
      RST_TRIM, RST_CEILING, RST_MHIGH, RST_MLOW, RST_MAKER, RST_PART};

   // ---------------------------------------------------------------
   // Margin selection from the operation register
   // ---------------------------------------------------------------
   localparam logic [1:0] MARGIN_OFF  = 2'h0;
   localparam logic [1:0] MARGIN_HIGH = 2'h1;
   localparam logic [1:0] MARGIN_LOW  = 2'h2;

   // ---------------------------------------------------------------
   // Scaling
   // ---------------------------------------------------------------
   localparam int STEP_UV      = 6250;
   localparam int TRIP_ADD_MV  = 400;
   localparam int TRIP_STEPS   = (TRIP_ADD_MV * 1000) / STEP_UV;
   localparam int DUTY_W       = 8;

endpackage : vout_limit_pkg
`default_nettype wire

// *** src/vout_clamp.sv ***
// Clamps a signed target between the floor and the ceiling
`timescale 1ns/1ps
`default_nettype none
module vout_clamp #(
   parameter int VW = 9
) (
   input  wire logic signed [VW+1:0] i_value,
   input  wire logic        [VW-1:0] i_floor,
   input  wire logic        [VW-1:0] i_ceil,
   output logic             [VW-1:0] o_value
);

   // Ceiling applied first, so the floor wins if the two cross
   always_comb begin
      logic signed [VW+1:0] v;
      v = i_value;
      if (v > $signed({2'b00, i_ceil})) begin
         v = $signed({2'b00, i_ceil});
      end
      if (v < $signed({2'b00, i_floor})) begin
         v = $signed({2'b00, i_floor});
      end
      o_value = v[VW-1:0];
   end

endmodule : vout_clamp
`default_nettype wire

// *** src/duty_target_map.sv ***
// Maps a measured duty linearly onto the floor to ceiling range
`timescale 1ns/1ps
`default_nettype none
module duty_target_map #(
   parameter int VW = 9,
   parameter int DW = 8
) (
   input  wire logic [DW-1:0] i_duty,
   input  wire logic [VW-1:0] i_floor,
   input  wire logic [VW-1:0] i_ceil,
   output logic      [VW-1:0] o_target
);

   localparam logic [DW-1:0]    DUTY_FULL = {DW{1'b1}};
   localparam logic [VW+DW-1:0] DIVISOR   = {{VW{1'b0}}, DUTY_FULL};

   logic [VW-1:0]    span;
   logic [VW+DW-1:0] prod;
   logic [VW+DW-1:0] quot;

   // Zero duty gives the floor, full duty gives the ceiling
   always_comb begin
      span     = (i_ceil > i_floor) ? (i_ceil - i_floor) : '0;
      prod     = {{DW{1'b0}}, span} * {{VW{1'b0}}, i_duty};
      quot     = prod / DIVISOR;
      o_target = i_floor + quot[VW-1:0];
   end

endmodule : duty_target_map
`default_nettype wire

// *** src/vout_limit_margin_regs.sv ***
// Output target register group: trim, ceiling, margins, user identity bytes
//
// Summary of operation
// R1 - Unused upper bits ignore writes and read back as zero.
// R2 - Trim byte is two's complement, bit 7 sign, 6.25 mV per step.
// R3 - In override mode the signed trim is added to the reference.
// R4 - Nine-bit ceiling, 6.25 mV steps; targets above it are clamped.
// R5 - Ceiling clamp applies in duty-cycle mode and override mode.
// R6 - Full duty on the duty input selects the ceiling as target.
// R7 - In override mode first overvoltage trip equals ceiling plus 400 mV.
// R8 - Margin high regulates to the nine-bit upper margin target.
// R9 - Margin low regulates to the nine-bit lower margin target.
// R10 - Eight-bit read/write user maker code register.
// R11 - Eight-bit read/write user part code register.
// R12 - Targets below floor are raised to it; zero duty selects floor.
// R13 - Override base target comes from the nine-bit command value.
// R14 - Override target is command plus trim, clamped floor to ceiling.
// R15 - Duty maps linearly between floor and ceiling in duty-cycle mode.
`timescale 1ns/1ps
`default_nettype none
module vout_limit_margin_regs #(
   parameter int VW = vout_limit_pkg::VID_W,
   parameter int DW = vout_limit_pkg::DUTY_W
) (
   input  wire logic          i_core_clk,
   input  wire logic          i_rst,
   input  wire logic          i_ce,
   input  wire logic [7:0]    i_cmd_code,
   input  wire logic          i_wr_en,
   input  wire logic [15:0]   i_wr_data,
   input  wire logic          i_rd_en,
   input  wire logic          i_override_mode,
   input  wire logic [1:0]    i_margin_sel,
   input  wire logic [VW-1:0] i_floor,
   input  wire logic [VW-1:0] i_command,
   input  wire logic [DW-1:0] i_duty,
   output logic      [15:0]   o_rd_data,
   output logic               o_rd_valid,
   output logic               o_cmd_unsup,
   output logic      [VW-1:0] o_target,
   output logic      [VW:0]   o_first_overvoltage_trip,
   output logic               o_trip_active
);

   // ---------------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------------
   function automatic logic code_hit(input logic [7:0] code);
      code_hit = (code >= vout_limit_pkg::CODE_TRIM) &&
                 (code <= vout_limit_pkg::CODE_PART);
   endfunction : code_hit

   function automatic logic [vout_limit_pkg::IDX_W-1:0] code_idx(input logic [7:0] code);
      logic [7:0] d;
      d        = code - vout_limit_pkg::CODE_TRIM;
      code_idx = d[vout_limit_pkg::IDX_W-1:0];
   endfunction : code_idx

   localparam int IX_TRIM  = 0;
   localparam int IX_CEIL  = 1;
   localparam int IX_MHIGH = 2;
   localparam int IX_MLOW  = 3;

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   logic [15:0] regs_q [vout_limit_pkg::NUM_REGS];

   genvar g;
   generate
      for (g = 0; g < vout_limit_pkg::NUM_REGS; g++) begin : g_reg
         always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               regs_q[g] <= vout_limit_pkg::REG_RESET[g];
            end else if (i_ce && i_wr_en && code_hit(i_cmd_code) &&
                         (code_idx(i_cmd_code) == g)) begin
               regs_q[g] <= i_wr_data & vout_limit_pkg::REG_MASK[g]; // R1 R10 R11
            end
         end

         AST_STORE_MASKED: assert property (@(posedge i_core_clk) disable iff (i_rst) // R1
            (regs_q[g] & ~vout_limit_pkg::REG_MASK[g]) == '0)
            else $error("stored register holds reserved bits");
      end
   endgenerate

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data   <= '0;
         o_rd_valid  <= 1'b0;
         o_cmd_unsup <= 1'b0;
      end else if (i_ce) begin
         o_rd_valid  <= i_rd_en;
         o_cmd_unsup <= (i_rd_en || i_wr_en) && !code_hit(i_cmd_code);
         if (i_rd_en && code_hit(i_cmd_code)) begin
            o_rd_data <= regs_q[code_idx(i_cmd_code)] &
                         vout_limit_pkg::REG_MASK[code_idx(i_cmd_code)]; // R1
         end else if (i_rd_en) begin
            o_rd_data <= '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Target selection
   // ---------------------------------------------------------------
   logic        [VW-1:0] ceil_v;
   logic        [VW-1:0] mhigh_v;
   logic        [VW-1:0] mlow_v;
   logic        [7:0]    trim_v;
   logic signed [VW+1:0] ovr_sum;
   logic        [VW-1:0] duty_tgt;
   logic signed [VW+1:0] raw_tgt;
   logic        [VW-1:0] clamp_tgt;

   assign ceil_v  = regs_q[IX_CEIL][VW-1:0];
   assign mhigh_v = regs_q[IX_MHIGH][VW-1:0];
   assign mlow_v  = regs_q[IX_MLOW][VW-1:0];
   assign trim_v  = regs_q[IX_TRIM][vout_limit_pkg::TRIM_W-1:0];

   // Sign-extended trim added to the command value
   assign ovr_sum = $signed({2'b00, i_command}) +
                    $signed({{(VW+2-vout_limit_pkg::TRIM_W){trim_v[vout_limit_pkg::TRIM_SIGN]}},
                             trim_v}); // R2 R3 R13 R14

   duty_target_map #(
      .VW       (VW),
      .DW       (DW)
   ) u_duty_map (
      .i_duty   (i_duty),
      .i_floor  (i_floor),
      .i_ceil   (ceil_v),
      .o_target (duty_tgt)
   ); // R6 R12 R15

   always_comb begin
      case (i_margin_sel)
         vout_limit_pkg::MARGIN_HIGH: raw_tgt = $signed({2'b00, mhigh_v}); // R8
         vout_limit_pkg::MARGIN_LOW:  raw_tgt = $signed({2'b00, mlow_v});  // R9
         default: begin
            if (i_override_mode) begin
               raw_tgt = ovr_sum; // R3
            end else begin
               raw_tgt = $signed({2'b00, duty_tgt});
            end
         end
      endcase
   end

   vout_clamp #(
      .VW      (VW)
   ) u_clamp (
      .i_value (raw_tgt),
      .i_floor (i_floor),
      .i_ceil  (ceil_v),
      .o_value (clamp_tgt)
   ); // R4 R5 R12 R14

   // ---------------------------------------------------------------
   // Target and trip outputs
   // ---------------------------------------------------------------
   localparam logic [VW:0] TRIP_OFFSET = (VW+1)'(vout_limit_pkg::TRIP_STEPS);

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_target <= '0;
      end else if (i_ce) begin
         o_target <= clamp_tgt; // R4 R5
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_first_overvoltage_trip <= '0;
         o_trip_active            <= 1'b0;
      end else if (i_ce) begin
         o_first_overvoltage_trip <= {1'b0, ceil_v} + TRIP_OFFSET; // R7
         o_trip_active            <= i_override_mode;              // R7
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   localparam logic [DW-1:0] DUTY_FULL = {DW{1'b1}};
   localparam int            DUTY_DIV  = int'(DUTY_FULL);

   logic [7:0] last_code_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         last_code_q <= '0;
      end else if (i_ce) begin
         last_code_q <= i_cmd_code;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   AST_RSVD_ZERO: assert property ( // R1
      o_rd_valid |-> (o_rd_data[15:VW] == '0) &&
         ((last_code_q == vout_limit_pkg::CODE_CEILING) ||
          (last_code_q == vout_limit_pkg::CODE_MHIGH) ||
          (last_code_q == vout_limit_pkg::CODE_MLOW) ||
          (o_rd_data[VW-1:vout_limit_pkg::TRIM_W] == '0)))
      else $error("reserved bits read non-zero");

   AST_OVR_TRIM: assert property ( // R3
      (i_ce && i_override_mode && i_margin_sel == vout_limit_pkg::MARGIN_OFF &&
       ovr_sum >= $signed({2'b00, i_floor}) && ovr_sum <= $signed({2'b00, ceil_v}))
      |=> (o_target == $past(i_command) +
           {{(VW-vout_limit_pkg::TRIM_W){$past(trim_v[vout_limit_pkg::TRIM_SIGN])}}, $past(trim_v)}))
      else $error("override target is not command plus trim");

   AST_TRIM_SIGN: assert property ( // R2
      (i_ce && i_override_mode && i_margin_sel == vout_limit_pkg::MARGIN_OFF &&
       trim_v[vout_limit_pkg::TRIM_SIGN] && i_command > i_floor && i_command <= ceil_v)
      |=> (o_target < $past(i_command)))
      else $error("negative trim did not lower the target");

   AST_CMD_BASE: assert property ( // R13
      (i_ce && i_override_mode && i_margin_sel == vout_limit_pkg::MARGIN_OFF && trim_v == '0 &&
       i_command >= i_floor && i_command <= ceil_v) |=> (o_target == $past(i_command)))
      else $error("override target is not the command value");

   AST_CEIL_CLAMP: assert property ( // R4
      (i_ce && ceil_v >= i_floor) |=> (o_target <= $past(ceil_v)))
      else $error("target above ceiling");

   AST_FLOOR_CLAMP: assert property ( // R12
      i_ce |=> (o_target >= $past(i_floor)))
      else $error("target below floor");

   AST_FULL_DUTY: assert property ( // R6
      (i_ce && !i_override_mode && i_margin_sel == vout_limit_pkg::MARGIN_OFF &&
       i_duty == DUTY_FULL && ceil_v >= i_floor) |=> (o_target == $past(ceil_v)))
      else $error("full duty did not select ceiling");

   AST_ZERO_DUTY: assert property ( // R12
      (i_ce && !i_override_mode && i_margin_sel == vout_limit_pkg::MARGIN_OFF &&
       i_duty == '0) |=> (o_target == $past(i_floor)))
      else $error("zero duty did not select floor");

   AST_DUTY_LINEAR: assert property ( // R15
      (i_ce && !i_override_mode && i_margin_sel == vout_limit_pkg::MARGIN_OFF && ceil_v > i_floor)
      |=> ((int'(o_target) - int'($past(i_floor))) * DUTY_DIV <=
           (int'($past(ceil_v)) - int'($past(i_floor))) * int'($past(i_duty))) &&
          ((int'(o_target) - int'($past(i_floor)) + 1) * DUTY_DIV >
           (int'($past(ceil_v)) - int'($past(i_floor))) * int'($past(i_duty))))
      else $error("duty target is off the linear map");

   AST_TRIP_LEVEL: assert property ( // R7
      (i_ce && i_override_mode) |=> o_trip_active &&
         (o_first_overvoltage_trip == {1'b0, $past(ceil_v)} + TRIP_OFFSET))
      else $error("trip level is not ceiling plus offset");

   AST_TRIP_IDLE: assert property ( // R7
      (i_ce && !i_override_mode) |=> !o_trip_active)
      else $error("trip flagged outside override mode");

   AST_MHIGH: assert property ( // R8
      (i_ce && i_margin_sel == vout_limit_pkg::MARGIN_HIGH &&
       mhigh_v >= i_floor && mhigh_v <= ceil_v) |=> (o_target == $past(mhigh_v)))
      else $error("margin high target wrong");

   AST_MLOW: assert property ( // R9
      (i_ce && i_margin_sel == vout_limit_pkg::MARGIN_LOW &&
       mlow_v >= i_floor && mlow_v <= ceil_v) |=> (o_target == $past(mlow_v)))
      else $error("margin low target wrong");

   AST_MARGIN_CLAMP: assert property ( // R4
      (i_ce && i_margin_sel == vout_limit_pkg::MARGIN_HIGH && mhigh_v > ceil_v && ceil_v >= i_floor)
      |=> (o_target == $past(ceil_v)))
      else $error("margin target not clamped to ceiling");

   AST_MAKER_RW: assert property ( // R10
      (i_ce && i_wr_en && i_cmd_code == vout_limit_pkg::CODE_MAKER) ##1
      (i_ce && i_rd_en && !i_wr_en && i_cmd_code == vout_limit_pkg::CODE_MAKER)
      |=> (o_rd_data == ($past(i_wr_data, 2) & vout_limit_pkg::MASK_BYTE)))
      else $error("maker code did not read back");

   AST_PART_RW: assert property ( // R11
      (i_ce && i_wr_en && i_cmd_code == vout_limit_pkg::CODE_PART) ##1
      (i_ce && i_rd_en && !i_wr_en && i_cmd_code == vout_limit_pkg::CODE_PART)
      |=> (o_rd_data == ($past(i_wr_data, 2) & vout_limit_pkg::MASK_BYTE)))
      else $error("part code did not read back");

   AST_UNMAPPED_RD: assert property ( // R1
      (i_ce && i_rd_en && !code_hit(i_cmd_code)) |=> (o_rd_valid && o_cmd_unsup && o_rd_data == '0))
      else $error("unmapped read not answered with zero");

   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------
   COV_OVR_CLAMPED: cover property (
      i_ce && i_override_mode && ovr_sum > $signed({2'b00, ceil_v}));
   COV_NEG_TRIM: cover property (
      i_ce && i_override_mode && trim_v[vout_limit_pkg::TRIM_SIGN]);
   COV_MID_DUTY: cover property (
      i_ce && !i_override_mode && i_duty != '0 && i_duty != DUTY_FULL);
   COV_UNSUP: cover property (o_cmd_unsup);

endmodule : vout_limit_margin_regs
`default_nettype wire

// *** sim/pmbus_host_model.sv ***
// Behavioural host that issues register writes and reads
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
   input  wire logic        i_core_clk,
   input  wire logic [15:0] i_rd_data,
   input  wire logic        i_rd_valid,
   input  wire logic        i_cmd_unsup,
   output var  logic [7:0]  o_cmd_code,
   output var  logic        o_wr_en,
   output var  logic [15:0] o_wr_data,
   output var  logic        o_rd_en
);
   initial begin
      o_cmd_code = 8'h00;
      o_wr_en    = 1'b0;
      o_wr_data  = 16'h0000;
      o_rd_en    = 1'b0;
   end

   // ---------------------------------------------------------------
   // Accesses: one strobe cycle, idle lines then show the inverse
   // ---------------------------------------------------------------
   task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
      @(negedge i_core_clk);
      o_cmd_code = code;
      o_wr_data  = data;
      o_wr_en    = 1'b1;
      @(negedge i_core_clk);
      o_wr_en    = 1'b0;
      o_cmd_code = ~code;
      o_wr_data  = ~data;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] code, output logic [15:0] data, output logic valid,
                           output logic unsup);
      @(negedge i_core_clk);
      o_cmd_code = code;
      o_rd_en    = 1'b1;
      @(negedge i_core_clk);
      o_rd_en    = 1'b0;
      o_cmd_code = ~code;
      data       = i_rd_data;
      valid      = i_rd_valid;
      unsup      = i_cmd_unsup;
   endtask : read_reg

   // Write followed by a read of the same code in the very next cycle
   task automatic write_read(input logic [7:0] code, input logic [15:0] data, output logic [15:0] rdata,
                             output logic valid);
      @(negedge i_core_clk);
      o_cmd_code = code;
      o_wr_data  = data;
      o_wr_en    = 1'b1;
      @(negedge i_core_clk);
      o_wr_en    = 1'b0;
      o_wr_data  = ~data;
      o_rd_en    = 1'b1;
      @(negedge i_core_clk);
      o_rd_en    = 1'b0;
      o_cmd_code = ~code;
      rdata      = i_rd_data;
      valid      = i_rd_valid;
   endtask : write_read
endmodule : pmbus_host_model
`default_nettype wire

// *** sim/vout_limit_margin_regs_tb.sv ***
// Self-checking testbench for the output target register group
`timescale 1ns/1ps
`default_nettype none
module vout_limit_margin_regs_tb;
   logic        i_core_clk, i_rst, i_ce, wr_en, rd_en, ovr, rd_valid, unsup, active;
   logic [7:0]  code, duty;
   logic [15:0] wr_data, rd_data;
   logic [1:0]  msel;
   logic [8:0]  floor_v, command, target;
   logic [9:0]  trip;
   int          errors, total_checks;

   vout_limit_margin_regs i_dut (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cmd_code(code), .i_wr_en(wr_en),
      .i_wr_data(wr_data), .i_rd_en(rd_en), .i_override_mode(ovr), .i_margin_sel(msel),
      .i_floor(floor_v), .i_command(command), .i_duty(duty), .o_rd_data(rd_data),
      .o_rd_valid(rd_valid), .o_cmd_unsup(unsup), .o_target(target),
      .o_first_overvoltage_trip(trip), .o_trip_active(active));

   pmbus_host_model i_host (
      .i_core_clk(i_core_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .i_cmd_unsup(unsup),
      .o_cmd_code(code), .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en));

   // ---------------------------------------------------------------
   // Clock and watchdog
   // ---------------------------------------------------------------
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   initial begin : watchdog
      #20000;
      errors = errors + 1;
      tally_and_finish();
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp, input logic exp_unsup);
      logic [15:0] d;
      logic        v;
      logic        u;
      i_host.read_reg(c, d, v, u);
      chk(d, exp);
      chk({14'h0000, v, u}, {14'h0000, 1'b1, exp_unsup});
   endtask : rd_chk

   task automatic wr_rd_chk(input logic [7:0] c, input logic [15:0] data, input logic [15:0] exp);
      logic [15:0] d;
      logic        v;
      i_host.write_read(c, data, d, v);
      chk(d, exp);
      chk({15'h0000, v}, 16'h0001);
   endtask : wr_rd_chk

   task automatic apply(input logic o, input logic [1:0] s, input logic [8:0] cmd, input logic [7:0] dt,
                        input logic [15:0] exp);
      @(negedge i_core_clk);
      ovr     = o;
      msel    = s;
      command = cmd;
      duty    = dt;
      repeat (2) @(negedge i_core_clk);
      chk({7'h00, target}, exp);
      chk({15'h0000, active}, {15'h0000, o});
   endtask : apply

   task automatic tally_and_finish();
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      errors       = 0;
      total_checks = 0;
      i_rst        = 1'b1;
      i_ce         = 1'b1;
      ovr          = 1'b0;
      msel         = 2'h0;
      floor_v      = 9'h00A;
      command      = 9'h000;
      duty         = 8'h00;
      repeat (16) @(posedge i_core_clk);
      @(negedge i_core_clk);
      i_rst = 1'b0;
      for (int i = 0; i < vout_limit_pkg::NUM_REGS; i++) begin
         rd_chk(8'h23 + 8'(i), vout_limit_pkg::REG_RESET[i], 1'b0);
      end
      for (int i = 0; i < vout_limit_pkg::NUM_REGS; i++) begin
         i_host.write_reg(8'h23 + 8'(i), 16'hFFFF);
         rd_chk(8'h23 + 8'(i), vout_limit_pkg::REG_MASK[i], 1'b0);
      end
      i_host.write_reg(8'h27, 16'h1234);
      i_host.write_reg(8'h28, 16'hABCD);
      i_host.write_reg(8'h23, 16'h12FE);
      rd_chk(8'h27, 16'h0034, 1'b0);
      rd_chk(8'h28, 16'h00CD, 1'b0);
      rd_chk(8'h23, 16'h00FE, 1'b0);
      // Write and read back to back
      wr_rd_chk(8'h27, 16'hFF34, 16'h0034);
      wr_rd_chk(8'h28, 16'h5ACD, 16'h00CD);
      // Unmapped codes on either side of the group
      i_host.write_reg(8'h29, 16'h00FF);
      chk({15'h0000, unsup}, 16'h0001);
      rd_chk(8'h29, 16'h0000, 1'b1);
      rd_chk(8'h22, 16'h0000, 1'b1);
      // Writes are not taken while the clock enable is low
      @(negedge i_core_clk);
      i_ce = 1'b0;
      i_host.write_reg(8'h27, 16'h0077);
      i_ce = 1'b1;
      rd_chk(8'h27, 16'h0034, 1'b0);
      // Override path: command plus signed trim, then clamped
      i_host.write_reg(8'h24, 16'h00C8);
      apply(1'b1, 2'h0, 9'h064, 8'h00, 16'h0062);
      chk({6'h00, trip}, 16'h0108);
      i_host.write_reg(8'h23, 16'h0000);
      apply(1'b1, 2'h0, 9'h0B4, 8'h00, 16'h00B4);
      i_host.write_reg(8'h23, 16'h007F);
      apply(1'b1, 2'h0, 9'h0BE, 8'h00, 16'h00C8);
      i_host.write_reg(8'h23, 16'h0080);
      apply(1'b1, 2'h0, 9'h005, 8'h00, 16'h000A);
      // Margin selection
      i_host.write_reg(8'h25, 16'h0096);
      i_host.write_reg(8'h26, 16'h0032);
      apply(1'b1, 2'h1, 9'h064, 8'h00, 16'h0096);
      apply(1'b0, 2'h2, 9'h064, 8'h00, 16'h0032);
      i_host.write_reg(8'h25, 16'h012C);
      apply(1'b1, 2'h1, 9'h064, 8'h00, 16'h00C8);
      apply(1'b1, 2'h3, 9'h064, 8'h00, 16'h000A);
      // Duty-cycle path, then override clamp and trip level with the ceiling lowered
      apply(1'b0, 2'h0, 9'h064, 8'h00, 16'h000A);
      apply(1'b0, 2'h0, 9'h064, 8'hFF, 16'h00C8);
      apply(1'b0, 2'h0, 9'h064, 8'h80, 16'h0069);
      i_host.write_reg(8'h24, 16'h0040);
      apply(1'b0, 2'h0, 9'h064, 8'hFF, 16'h0040);
      apply(1'b1, 2'h0, 9'h1F0, 8'h00, 16'h0040);
      chk({6'h00, trip}, 16'h0080);
      tally_and_finish();
   end
endmodule : vout_limit_margin_regs_tb
`default_nettype wire
